// ===== tx_frame_sync_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  transmit system timing block.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef TX_FRAME_SYNC_DEFS_SVH
`define TX_FRAME_SYNC_DEFS_SVH

`define A_GLOBAL 4'h0
`define A_ES_EN 4'h1
`define A_SYNC_OUT 4'h2
`define A_MF_SEL 4'h3
`define A_T1_MODE 4'h4
`define A_DBL_EN 4'h5
`define A_IBO_EN 4'h6
`define A_STATUS 4'h7
`define A_MASK 4'h8
`define A_LIVE 4'h9

`define G_LEGACY 0
`define G_SEL_LSB 1
`define G_SEL_MSB 2
`define G_SHARED_OUT 3

`define REG_RESET 8'h00

`define T1_BIT_LAST 8'hC0
`define E1_BIT_LAST 8'hFF
`define T1_FRM_LAST 5'h17
`define E1_FRM_LAST 5'h0F
`define SIG_FRM_A 5'h05
`define SIG_FRM_B 5'h0B
`define SIG_FRM_C 5'h11
`define SIG_FRM_D 5'h17

`define FRAME_RATE_HZ 8000
`define BP_RATE_HZ 16384000
`define BP_CLKS_PER_FRAME (`BP_RATE_HZ / `FRAME_RATE_HZ)

`endif

// ===== tx_frame_sync_pkg.sv
/*
  Types shared by the transmit system timing block.
  Assumes tx_frame_sync_defs.svh is on the include path.
*/
package tx_frame_sync_pkg;

  typedef enum logic [1:0] {
    SEL_ANALOG_LOSS = 2'h0,
    SEL_FRAMER_LOSS = 2'h1,
    SEL_SIG_FREEZE = 2'h2,
    SEL_NONE = 2'h3
  } status_sel_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_LAST = 2'h1,
    P_WIDE = 2'h3
  } pulse_state_t;

  typedef struct packed {
    logic [7:0] in;
    logic [7:0] out;
    logic [7:0] oe;
  } pin8_t;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pin1_t;

endpackage

// ===== edge_sync.sv
/*
  Two-flop synchroniser with edge detection for a group of slow inputs.
  Assumes inputs are asynchronous to clk_sys and slow against it.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta <= '0;
      lvl <= '0;
      prev <= '0;
    end else begin
      meta <= din;
      lvl <= meta;
      prev <= lvl;
    end
  end

  assign rise = lvl & ~prev;
  assign fall = ~lvl & prev;
endmodule
`default_nettype wire

// ===== tx_system_timing_sync.sv
/*
  Transmit system timing and sync pins of an eight-port framer.
  Assumes slow pin clocks sampled by clk_sys, register port on clk_sys,
  status levels from clk_sys logic.
*/
// The address map and the plain strobed port were decided locally.
// Functional notes
// - System clock used with elastic store or interleaved bus
// - Legacy mode: port one system clock drives all system-clocked ports
// - Legacy mode turns pins two-eight into outputs
// - Status output selected by clock control field
// - Sync input pulse aligns frame, line clock
// - Sync output pulses at frame or multiframe
// - T1 signaling frames get double-wide pulse
// - Elastic store: sync sampled on system clock
// - Shared sync output: 8kHz on backplane clock
// - Legacy mode: system-clocked ports use shared sync pin only
// - No store, no interleave: line clock samples
`include "tx_frame_sync_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tx_system_timing_sync #(
  parameter int unsigned BP_DIV = `BP_CLKS_PER_FRAME
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic [7:0] tx_line_clock,
  input wire logic [7:0] tx_system_clock_in,
  output logic [7:0] tx_system_clock_out,
  output logic [7:0] tx_system_clock_oe,
  input wire logic [7:0] tx_frame_sync_in,
  output logic [7:0] tx_frame_sync_out,
  output logic [7:0] tx_frame_sync_oe,
  input wire logic tx_system_sync_io_in,
  output logic tx_system_sync_io_out,
  output logic tx_system_sync_io_oe,
  input wire logic backplane_clock_first,
  input wire logic [7:0] analog_signal_loss,
  input wire logic [7:0] framer_signal_loss,
  input wire logic [7:0] rx_signaling_freeze,
  output logic [7:0] tx_bit_strobe,
  output logic [7:0] tx_frame_start
);
  import tx_frame_sync_pkg::*;

  localparam logic [15:0] BP_LAST = 16'(BP_DIV - 1);

  logic [7:0] global_ctrl, es_en, sync_out, mf_sel, t1_mode, dbl_en, ibo_en;
  logic [7:0] status, mask;
  logic [7:0] next_global_ctrl, next_es_en, next_sync_out, next_mf_sel;
  logic [7:0] next_t1_mode, next_dbl_en, next_ibo_en, next_status, next_mask;
  logic [7:0] next_reg_rdata;
  logic next_irq;

  logic legacy, shared_out_en;
  status_sel_t stat_sel;
  pin8_t sys_pin, fs_pin;
  pin1_t shared_pin;

  logic [25:0] raw_in, lvl_in, rise_in, fall_in;
  logic [7:0] line_fall, sys_fall, fs_lvl;
  logic shared_lvl, bp_rise;

  wire [7:0] use_sys, tick, sync_lvl, hit, bnd, samp_v, fs_next;

  logic [7:0] bit_cnt [8];
  logic [7:0] next_bit_cnt [8];
  logic [4:0] frm_cnt [8];
  logic [4:0] next_frm_cnt [8];
  logic samp [8];
  logic next_samp [8];
  pulse_state_t pst [8];
  pulse_state_t next_pst [8];

  logic [15:0] bp_cnt, next_bp_cnt;
  logic shared_pulse, next_shared_pulse;
  logic [7:0] next_sys_out;
  logic next_sys_oe;

  assign legacy = global_ctrl[`G_LEGACY];
  assign shared_out_en = global_ctrl[`G_SHARED_OUT];
  assign stat_sel = status_sel_t'(global_ctrl[`G_SEL_MSB:`G_SEL_LSB]);

  // Pin inputs through two flops
  assign raw_in = {backplane_clock_first, tx_system_sync_io_in,
                   tx_frame_sync_in, tx_system_clock_in, tx_line_clock};

  edge_sync #(.W(26)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(raw_in),
    .lvl(lvl_in),
    .rise(rise_in),
    .fall(fall_in)
  );

  assign line_fall = fall_in[7:0];
  assign sys_fall = fall_in[15:8];
  assign fs_lvl = lvl_in[23:16];
  assign shared_lvl = lvl_in[24];
  assign bp_rise = rise_in[25];

  function automatic logic sig_frame(input logic [4:0] f);
    sig_frame = (f == `SIG_FRM_A) || (f == `SIG_FRM_B) ||
                (f == `SIG_FRM_C) || (f == `SIG_FRM_D);
  endfunction

  // Per-port timing
  for (genvar i = 0; i < 8; i++) begin : g_port
    logic [7:0] bit_last;
    logic [4:0] frm_last;
    logic align, wide;

    assign use_sys[i] = es_en[i] | ibo_en[i];
    assign tick[i] = use_sys[i] ? (legacy ? sys_fall[0] : sys_fall[i])
                                : line_fall[i];
    assign sync_lvl[i] = (legacy && use_sys[i]) ? shared_lvl
                                                : fs_lvl[i];
    assign bit_last = t1_mode[i] ? `T1_BIT_LAST : `E1_BIT_LAST;
    assign frm_last = t1_mode[i] ? `T1_FRM_LAST : `E1_FRM_LAST;
    assign align = tick[i] && !sync_out[i] && sync_lvl[i] && !samp[i];
    assign hit[i] = align;
    assign bnd[i] = tick[i] && (next_bit_cnt[i] == 8'h00) &&
                    (!mf_sel[i] || (next_frm_cnt[i] == 5'h00));
    assign wide = !mf_sel[i] && t1_mode[i] && dbl_en[i] &&
                  sig_frame(next_frm_cnt[i]);
    assign samp_v[i] = samp[i];
    assign fs_next[i] = (next_pst[i] != P_IDLE);

    always_comb begin
      next_bit_cnt[i] = bit_cnt[i];
      next_frm_cnt[i] = frm_cnt[i];
      next_samp[i] = samp[i];
      if (tick[i]) begin
        next_samp[i] = sync_lvl[i];
        if (align) begin
          next_bit_cnt[i] = 8'h00;
          if (mf_sel[i]) begin
            next_frm_cnt[i] = 5'h00;
          end
        end else if (bit_cnt[i] == bit_last) begin
          next_bit_cnt[i] = 8'h00;
          if (frm_cnt[i] >= frm_last) begin
            next_frm_cnt[i] = 5'h00;
          end else begin
            next_frm_cnt[i] = frm_cnt[i] + 5'h01;
          end
        end else begin
          next_bit_cnt[i] = bit_cnt[i] + 8'h01;
        end
      end
    end

    always_comb begin
      next_pst[i] = pst[i];
      if (!sync_out[i]) begin
        next_pst[i] = P_IDLE;
      end else if (tick[i]) begin
        unique case (pst[i])
          P_IDLE: begin
            if (bnd[i]) begin
              next_pst[i] = wide ? P_WIDE : P_LAST;
            end
          end
          P_WIDE: begin
            next_pst[i] = P_LAST;
          end
          P_LAST: begin
            next_pst[i] = P_IDLE;
          end
          default: begin
            next_pst[i] = P_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        bit_cnt[i] <= 8'h00;
        frm_cnt[i] <= 5'h00;
        samp[i] <= 1'b0;
        pst[i] <= P_IDLE;
      end else begin
        bit_cnt[i] <= next_bit_cnt[i];
        frm_cnt[i] <= next_frm_cnt[i];
        samp[i] <= next_samp[i];
        pst[i] <= next_pst[i];
      end
    end
  end

  // Shared sync pin, status outputs, registers
  always_comb begin
    next_bp_cnt = bp_cnt;
    next_shared_pulse = shared_pulse;
    if (!(shared_out_en && (|es_en))) begin
      next_bp_cnt = 16'h0000;
      next_shared_pulse = 1'b0;
    end else if (bp_rise) begin
      next_shared_pulse = (bp_cnt == BP_LAST);
      next_bp_cnt = (bp_cnt == BP_LAST) ? 16'h0000 : bp_cnt + 16'h0001;
    end
    next_sys_oe = legacy;
    next_sys_out = 8'h00;
    if (legacy) begin
      unique case (stat_sel)
        SEL_ANALOG_LOSS: next_sys_out = analog_signal_loss;
        SEL_FRAMER_LOSS: next_sys_out = framer_signal_loss;
        SEL_SIG_FREEZE: next_sys_out = rx_signaling_freeze;
        SEL_NONE: next_sys_out = 8'h00;
      endcase
      next_sys_out[0] = 1'b0;
    end
  end

  always_comb begin
    next_global_ctrl = global_ctrl;
    next_es_en = es_en;
    next_sync_out = sync_out;
    next_mf_sel = mf_sel;
    next_t1_mode = t1_mode;
    next_dbl_en = dbl_en;
    next_ibo_en = ibo_en;
    next_mask = mask;
    next_status = status;
    if (reg_wr) begin
      unique case (reg_addr)
        `A_GLOBAL: next_global_ctrl = {4'h0, reg_wdata[3:0]};
        `A_ES_EN: next_es_en = reg_wdata;
        `A_SYNC_OUT: next_sync_out = reg_wdata;
        `A_MF_SEL: next_mf_sel = reg_wdata;
        `A_T1_MODE: next_t1_mode = reg_wdata;
        `A_DBL_EN: next_dbl_en = reg_wdata;
        `A_IBO_EN: next_ibo_en = reg_wdata;
        `A_STATUS: next_status = status & ~reg_wdata;
        `A_MASK: next_mask = reg_wdata;
        default: next_mask = mask;
      endcase
    end
    next_status = next_status | hit;
    next_irq = |(next_status & next_mask);
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `A_GLOBAL: next_reg_rdata = global_ctrl;
        `A_ES_EN: next_reg_rdata = es_en;
        `A_SYNC_OUT: next_reg_rdata = sync_out;
        `A_MF_SEL: next_reg_rdata = mf_sel;
        `A_T1_MODE: next_reg_rdata = t1_mode;
        `A_DBL_EN: next_reg_rdata = dbl_en;
        `A_IBO_EN: next_reg_rdata = ibo_en;
        `A_STATUS: next_reg_rdata = status;
        `A_MASK: next_reg_rdata = mask;
        `A_LIVE: next_reg_rdata = samp_v;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      global_ctrl <= `REG_RESET;
      es_en <= `REG_RESET;
      sync_out <= `REG_RESET;
      mf_sel <= `REG_RESET;
      t1_mode <= `REG_RESET;
      dbl_en <= `REG_RESET;
      ibo_en <= `REG_RESET;
      status <= `REG_RESET;
      mask <= `REG_RESET;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
      bp_cnt <= 16'h0000;
      shared_pulse <= 1'b0;
      sys_pin.out <= 8'h00;
      sys_pin.oe <= 8'h00;
      fs_pin.out <= 8'h00;
      fs_pin.oe <= 8'h00;
      shared_pin.oe <= 1'b0;
      tx_bit_strobe <= 8'h00;
      tx_frame_start <= 8'h00;
    end else begin
      global_ctrl <= next_global_ctrl;
      es_en <= next_es_en;
      sync_out <= next_sync_out;
      mf_sel <= next_mf_sel;
      t1_mode <= next_t1_mode;
      dbl_en <= next_dbl_en;
      ibo_en <= next_ibo_en;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
      reg_rdata <= next_reg_rdata;
      bp_cnt <= next_bp_cnt;
      shared_pulse <= next_shared_pulse;
      sys_pin.out <= next_sys_out;
      sys_pin.oe <= {{7{next_sys_oe}}, 1'b0};
      fs_pin.out <= fs_next;
      fs_pin.oe <= next_sync_out;
      shared_pin.oe <= next_global_ctrl[`G_SHARED_OUT];
      tx_bit_strobe <= tick;
      tx_frame_start <= bnd;
    end
  end

  assign sys_pin.in = tx_system_clock_in;
  assign fs_pin.in = tx_frame_sync_in;
  assign shared_pin.in = tx_system_sync_io_in;
  assign shared_pin.out = shared_pulse;
  assign tx_system_clock_out = sys_pin.out;
  assign tx_system_clock_oe = sys_pin.oe;
  assign tx_frame_sync_out = fs_pin.out;
  assign tx_frame_sync_oe = fs_pin.oe;
  assign tx_system_sync_io_out = shared_pin.out;
  assign tx_system_sync_io_oe = shared_pin.oe;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_SYS_PIN_DIR: assert property (
    legacy |=> (tx_system_clock_oe == 8'hFE))
    else $error("Status pins not driven in legacy mode");
  AST_STATUS_SEL: assert property (
    legacy && (stat_sel == SEL_FRAMER_LOSS) |=>
      (tx_system_clock_out[7:1] == $past(framer_signal_loss[7:1])))
    else $error("Status output does not follow selected source");
  AST_LEGACY_CLK: assert property (
    legacy && es_en[5] |-> (tick[5] == sys_fall[0]))
    else $error("Legacy port not clocked from port one");
  AST_LINE_CLK: assert property (
    !es_en[2] && !ibo_en[2] |-> (tick[2] == line_fall[2]))
    else $error("Line clock not used with store off");
  AST_SHARED_SYNC: assert property (
    legacy && es_en[3] |-> (sync_lvl[3] == shared_lvl))
    else $error("Per-port sync used in legacy mode");
  AST_ALIGN: assert property (
    hit[3] |=> (bit_cnt[3] == 8'h00) ##1 (status[3] || $past(reg_wr)))
    else $error("Sync pulse did not align the frame");
  AST_FRAME_OUT: assert property (
    $rose(tx_frame_sync_out[0]) |-> $past(bnd[0]) && $past(sync_out[0]))
    else $error("Sync output pulse off the boundary");
  AST_WIDE: assert property (
    (pst[0] == P_WIDE) && ($past(pst[0]) == P_IDLE) |->
      $past(t1_mode[0] && dbl_en[0] && !mf_sel[0]) && sig_frame(frm_cnt[0]))
    else $error("Wide pulse outside T1 signaling frame");
  AST_SHARED_OUT: assert property (
    $rose(tx_system_sync_io_out) |-> $past(bp_rise) && tx_system_sync_io_oe)
    else $error("Shared sync pulse not on backplane edge");
  AST_STORE_OFF: assert property (
    !use_sys[4] && tick[4] |-> line_fall[4])
    else $error("System clock used with store off");

  COV_ALIGN: cover property (hit[0] ##[1:400] tx_frame_start[0]);
  COV_WIDE: cover property (pst[0] == P_WIDE ##1 pst[0] == P_LAST);
  COV_SHARED: cover property ($rose(tx_system_sync_io_out));
  COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== backplane_model.sv
/*
  Backplane side model: line, system and backplane clocks, sync pulses.
  Assumes the bench gates each clock and requests sync pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
  input wire logic [7:0] line_run,
  input wire logic [7:0] sys_run,
  input wire logic bp_run,
  input wire logic [7:0] sync_req,
  output logic [7:0] line_clk,
  output logic [7:0] sys_clk,
  output logic bp_clk,
  output logic [7:0] sync_pin
);
  // Clocks stand still while not run, phases unrelated to clk_sys
  initial begin
    line_clk = 8'h00;
    #37;
    forever #160 line_clk = line_clk ^ line_run;
  end
  initial begin
    sys_clk = 8'h00;
    #83;
    forever #160 sys_clk = sys_clk ^ sys_run;
  end
  initial begin
    bp_clk = 1'b0;
    #11;
    forever #160 bp_clk = bp_clk ^ bp_run;
  end
  initial sync_pin = 8'h00;
  // Pulse launched on line clock rising edge, one period wide
  for (genvar i = 0; i < 8; i++) begin : g_sync
    always @(posedge line_clk[i]) sync_pin[i] <= sync_req[i];
  end
endmodule
`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench for the transmit system timing block.
  Assumes the design files and backplane_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tx_frame_sync_defs.svh"
module tb;
  import tx_frame_sync_pkg::*;
  localparam int BPD = 8;
  logic clk_sys, reset, reg_wr, reg_rd, irq, bp_run, bp_clk, ss_out, ss_oe, ss_d, ss_in;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, line_run, sys_run, sync_req, line_clk, sys_clk, sync_pin;
  logic [7:0] sc_out, sc_oe, fs_out, fs_oe, al, fl, rf, strobe, fstart, v;
  logic [15:0] lfsr;
  int bad_count, compares, cyc, b0, n3, ss_last, ss_gap, ss_n;
  int regm [16];
  int st_cnt [8], gap [8], last [8], wide [8], hi [8], nstart [8], wb [8], nb [8];

  tx_system_timing_sync #(.BP_DIV(BPD)) dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .tx_line_clock(line_clk), .tx_system_clock_in(sys_clk),
    .tx_system_clock_out(sc_out), .tx_system_clock_oe(sc_oe),
    .tx_frame_sync_in(sync_pin), .tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe),
    .tx_system_sync_io_in(ss_in), .tx_system_sync_io_out(ss_out),
    .tx_system_sync_io_oe(ss_oe), .backplane_clock_first(bp_clk),
    .analog_signal_loss(al), .framer_signal_loss(fl), .rx_signaling_freeze(rf),
    .tx_bit_strobe(strobe), .tx_frame_start(fstart)
  );
  backplane_model partner (
    .line_run(line_run), .sys_run(sys_run), .bp_run(bp_run), .sync_req(sync_req),
    .line_clk(line_clk), .sys_clk(sys_clk), .bp_clk(bp_clk), .sync_pin(sync_pin)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 4'h7)
      regm[7] = regm[7] & ~d;
    else if (a == 4'h0)
      regm[0] = d & 8'h0F;
    else if (a < 4'h9)
      regm[a] = d;
  endtask

  task automatic rc(logic [3:0] a, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk("reg_rdata", v, e);
  endtask

  task automatic wait_start(int p, int n);
    repeat (40000) begin
      @(posedge clk_sys);
      if (nstart[p] >= n) break;
    end
  endtask

  // Counts ticks per port over 20 clock periods of the pin clocks
  task automatic ticks(logic [7:0] e);
    int b [8];
    b = st_cnt;
    repeat (160) @(posedge clk_sys);
    for (int p = 0; p < 8; p++)
      chk("tick_rate", e[p] ? (st_cnt[p] - b[p] inside {[18:22]}) : st_cnt[p] == b[p], 1);
  endtask

  // Tick, frame, pulse width and shared pulse bookkeeping
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      bad_count++;
      final_report();
    end
    for (int p = 0; p < 8; p++) begin
      st_cnt[p] <= st_cnt[p] + strobe[p];
      hi[p] <= fs_out[p] ? hi[p] + 1 : 0;
      if (!fs_out[p] && hi[p] > 12) wide[p] <= wide[p] + 1;
      if (fstart[p]) begin
        gap[p] <= st_cnt[p] - last[p];
        last[p] <= st_cnt[p];
        nstart[p] <= nstart[p] + 1;
      end
    end
    ss_d <= ss_out;
    if (ss_out && !ss_d) begin
      ss_gap <= cyc - ss_last;
      ss_last <= cyc;
      ss_n <= ss_n + 1;
    end
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    line_run = 8'h00;
    sys_run = 8'h00;
    bp_run = 1'b0;
    sync_req = 8'h00;
    ss_in = 1'b0;
    al = 8'h00;
    fl = 8'h00;
    rf = 8'h00;
    lfsr = 16'hB206;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++) rc(4'(a), `REG_RESET);
    for (int a = 0; a < 16; a++) begin
      lfsr = nx(lfsr);
      if (a != 7 && a != 9) begin
        wr(4'(a), lfsr[7:0]);
        rc(4'(a), 8'(regm[a]));
      end
    end
    for (int a = 0; a < 9; a++) wr(4'(a), 8'h00);
    wr(`A_STATUS, 8'hFF);
    // Legacy mode status pins, every selection
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      lfsr = nx(lfsr);
      al <= lfsr[7:0];
      fl <= lfsr[15:8];
      rf <= lfsr[11:4];
      wr(4'h0, 8'(s * 2 + 1));
      repeat (3) @(posedge clk_sys);
      #1;
      chk("sc_oe", sc_oe, 8'hFE);
      chk("sc_out", sc_out, (s == 0 ? al : s == 1 ? fl : s == 2 ? rf : 8'h00) & 8'hFE);
    end
    wr(4'h0, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("sc_oe", sc_oe, 8'h00);
    // Clock source selection
    @(posedge clk_sys);
    line_run <= 8'h0F;
    sys_run <= 8'h11;
    wr(4'h1, 8'h22);
    repeat (20) @(posedge clk_sys);
    ticks(8'h0D);
    // Interleaved bus on port 4 runs from its system clock
    wr(4'h6, 8'h10);
    repeat (20) @(posedge clk_sys);
    ticks(8'h1D);
    wr(4'h6, 8'h00);
    wr(4'h0, 8'h01);
    repeat (20) @(posedge clk_sys);
    ticks(8'h2F);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    // Frame pulses: T1 double, E1 double, T1 plain
    wr(4'h2, 8'h07);
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h03);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("fs_oe", fs_oe, 8'h07);
    wait_start(2, nstart[2] + 2);
    wb = wide;
    nb = nstart;
    wait_start(2, nb[2] + 6);
    chk("gap0", gap[0], 193);
    chk("gap1", gap[1], 256);
    chk("gap2", gap[2], 193);
    chk("wide0", wide[0] - wb[0], 1);
    chk("wide1", wide[1] - wb[1], 0);
    chk("wide2", wide[2] - wb[2], 0);
    wr(4'h3, 8'h02);
    nb = nstart;
    repeat (4200) @(posedge clk_sys);
    chk("mf_starts", nstart[1] - nb[1] <= 1, 1);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    // Sync input alignment, refused on an output port
    wr(4'h2, 8'h02);
    wr(`A_MASK, 8'h08);
    @(posedge clk_sys);
    sync_req <= 8'h0A;
    b0 = st_cnt[3];
    n3 = nstart[3];
    repeat (8) @(posedge clk_sys);
    sync_req <= 8'h00;
    repeat (16) @(posedge clk_sys);
    rc(`A_STATUS, 8'h08);
    chk("irq", irq, 1'b1);
    wait_start(3, n3 + 1);
    chk("align", last[3] - b0 inside {[0:3], [254:258]}, 1);
    wr(`A_MASK, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", irq, 1'b0);
    wr(`A_STATUS, 8'h08);
    rc(`A_STATUS, 8'h00);
    // Shared pulse every BPD periods of the backplane clock
    wr(4'h0, 8'h08);
    wr(4'h1, 8'h01);
    bp_run <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("ss_oe", ss_oe, 1'b1);
    b0 = ss_n;
    repeat (800) begin
      @(posedge clk_sys);
      if (ss_n >= b0 + 3) break;
    end
    chk("ss_gap", ss_gap inside {[BPD * 8 - 2:BPD * 8 + 2]}, 1);
    // Legacy mode: shared sync pin aligns port 3, its own pin is ignored
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h08);
    wr(`A_STATUS, 8'hFF);
    @(posedge clk_sys);
    sync_req <= 8'h08;
    repeat (8) @(posedge clk_sys);
    sync_req <= 8'h00;
    repeat (16) @(posedge clk_sys);
    rc(`A_STATUS, 8'h00);
    ss_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    ss_in <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rc(`A_STATUS, 8'h08);
    final_report();
  end
endmodule
`default_nettype wire
